// >>> hdl/frc_pkg.sv
// constants shared by the fault response configuration block
package frc_pkg;

   localparam int WORD_W = 26;
   localparam int ADDR_W = 7;
   localparam int FLAG_W = 12;
   localparam int HOLD_CNT_W = 8;
   localparam int PCT_W = 7;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets on the programming link
   localparam logic [ADDR_W-1:0] OFS_CFG_NV = 7'h3C;
   localparam logic [ADDR_W-1:0] OFS_CFG_SHADOW = 7'h7C;
   localparam logic [ADDR_W-1:0] OFS_MASK_NV = 7'h3D;
   localparam logic [ADDR_W-1:0] OFS_MASK_SHADOW = 7'h7D;
   localparam logic [ADDR_W-1:0] OFS_UNLOCK = 7'h7E;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h7F;

   ////////////////////////////////////////////////////////////////////////////
   // output lock and error response word fields
   localparam int BIT_ANA_CODE_REQ = 25;
   localparam int MEMLOCK_HI = 24;
   localparam int MEMLOCK_LO = 21;
   localparam int ENTRY_HI = 20;
   localparam int ENTRY_LO = 19;
   localparam int BIT_TEST_DIS = 18;
   localparam int BIT_OV_SEL = 17;
   localparam int BIT_UV_SEL = 16;
   localparam int SPARE_HI = 15;
   localparam int SPARE_LO = 13;
   localparam int DAC_HI = 12;
   localparam int DAC_LO = 10;
   localparam int BIT_FILT = 9;
   localparam int BIT_DIG_RESP = 8;
   localparam int ANA_RESP_HI = 7;
   localparam int ANA_RESP_LO = 6;
   localparam int HOLD_HI = 5;
   localparam int HOLD_LO = 3;
   localparam int BIT_ANALOG_EVENT_ENTRY_LOCK = 2;
   localparam int BIT_RX_RISE = 1;
   localparam int BIT_RX_FALL = 0;

   ////////////////////////////////////////////////////////////////////////////
   // error flag mask word fields
   localparam int MASK_OV = 11;
   localparam int MASK_UV = 10;
   localparam int MASK_SIG_PATH = 9;
   localparam int MASK_MEM_SBE = 8;
   localparam int MASK_POR = 7;
   localparam int MASK_RADIUS = 6;
   localparam int MASK_LOGIC = 5;
   localparam int MASK_OSC = 4;
   localparam int MASK_SAT = 3;
   localparam int MASK_TEMP = 2;
   localparam int MASK_CLAMP = 1;
   localparam int MASK_ANA_CHECK = 0;

   ////////////////////////////////////////////////////////////////////////////
   // codes and reset values
   localparam logic [1:0] ENTRY_OV_OR_FUNC = 2'h0;
   localparam logic [1:0] ENTRY_OV_ONLY = 2'h1;
   localparam logic [1:0] ENTRY_FUNC_ONLY = 2'h2;
   localparam logic [1:0] ENTRY_NONE = 2'h3;
   localparam logic [1:0] ANA_RESP_HIZ_A = 2'h0;
   localparam logic [1:0] ANA_RESP_HIGH = 2'h1;
   localparam logic [1:0] ANA_RESP_LOW = 2'h2;
   localparam logic [1:0] ANA_RESP_HIZ_B = 2'h3;
   localparam logic [WORD_W-1:0] CFG_NV_RESET = 26'h0000000;
   localparam logic [WORD_W-1:0] MASK_NV_RESET = 26'h0000000;
   localparam logic [WORD_W-1:0] UNLOCK_CODE_DEFAULT = 26'h2C3A5D1;

   typedef enum {FRC_LOAD, FRC_RUN} frc_phase_type;

endpackage : frc_pkg

// >>> hdl/frc_hold_if.sv
// hold-off counter connection between the top and its counters
`timescale 1ns/10ps
`default_nettype none
interface frc_hold_if;
   logic cond;
   logic update;
   logic [frc_pkg::HOLD_CNT_W-1:0] target;
   logic active;
   modport owner (output cond, output update, output target, input active);
   modport counter (input cond, input update, input target, output active);
endinterface : frc_hold_if
`default_nettype wire

// >>> hdl/frc_hold_counter.sv
// counts condition-free updates after a condition ends
`timescale 1ns/10ps
`default_nettype none
module frc_hold_counter (
   input wire logic clk_i,
   input wire logic reset_n_i,
   frc_hold_if.counter hold
);
   logic armed;
   logic [frc_pkg::HOLD_CNT_W-1:0] count;

   // a new condition restarts the run of clean updates
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         armed <= 1'b0;
         count <= '0;
      end else if (hold.cond) begin
         armed <= 1'b1;
         count <= '0;
      end else if (armed && count >= hold.target) begin
         armed <= 1'b0;
         count <= '0;
      end else if (armed && hold.update) begin
         count <= count + 1'b1;
      end
   end

   assign hold.active = hold.cond | (armed & (count < hold.target));
endmodule : frc_hold_counter
`default_nettype wire

// >>> hdl/frc_config_top.sv
// fault response configuration: nv and shadow words, masking, locks, output responses
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - mask bits 11..7 hide OV,UV,path,SBE,POR flags
// - mask bits 6..0 hide remaining seven flags
// - masking never alters position data
// - analog lock needs unlock code first
// - nonzero memory lock rejects nv writes
// - entry field selects allowed entry triggers
// - entry code 11 refuses all communication
// - test disable blocks margin tests
// - select bits pick OV/UV threshold
// - spare bits stored, no effect
// - DAC span code picks output scaling
// - filter bit picks 15/30 kHz corner
// - clear bit: PWM half freq, SENT diag
// - set bit: digital output high-Z on error
// - analog response: high-Z, high or low
// - analog release after clean update count
// - digital UV report held after recovery
// - analog lock needs analog entry event
// - rise threshold select for receiver
// - fall threshold select, digital entry level
module frc_config_top #(
   parameter logic [frc_pkg::WORD_W-1:0] CFG_NV_INIT = frc_pkg::CFG_NV_RESET,
   parameter logic [frc_pkg::WORD_W-1:0] MASK_NV_INIT = frc_pkg::MASK_NV_RESET,
   parameter logic [frc_pkg::WORD_W-1:0] UNLOCK_CODE = frc_pkg::UNLOCK_CODE_DEFAULT
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic prog_req_i,
   input wire logic prog_we_i,
   input wire logic [frc_pkg::ADDR_W-1:0] prog_addr_i,
   input wire logic [frc_pkg::WORD_W-1:0] prog_wdata_i,
   output logic prog_ack_o,
   output logic prog_refused_o,
   output logic [frc_pkg::WORD_W-1:0] prog_rdata_o,
   output logic prog_enabled_o,
   input wire logic analog_mode_i,
   input wire logic sent_mode_i,
   input wire logic func_pulse_i,
   input wire logic ana_entry_i,
   input wire logic ov_above_lo_i,
   input wire logic ov_above_hi_i,
   input wire logic uv_below_lo_i,
   input wire logic uv_below_hi_i,
   input wire logic [9:0] flags_i,
   input wire logic angle_update_i,
   input wire logic [15:0] pos_data_i,
   output logic [15:0] pos_data_o,
   output logic [frc_pkg::FLAG_W-1:0] reported_flags_o,
   output logic error_active_o,
   output logic pwm_half_freq_o,
   output logic sent_diag_error_o,
   output logic dig_out_hiz_o,
   output logic ana_hiz_o,
   output logic ana_force_high_o,
   output logic ana_force_low_o,
   output logic uv_report_o,
   output logic [frc_pkg::PCT_W-1:0] dac_span_low_pct_o,
   output logic [frc_pkg::PCT_W-1:0] dac_span_high_pct_o,
   output logic analog_filter_corner_select_o,
   output logic prog_rx_rise_level_select_o,
   output logic prog_rx_fall_level_select_o,
   input wire logic margin_test_req_i,
   output logic margin_test_en_o
);
   if (UNLOCK_CODE == '0) begin : g_check
      $error("unlock code must be nonzero");
   end

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // span code to low and high percent of supply
   function automatic logic [2*frc_pkg::PCT_W-1:0] dac_span(input logic [2:0] code);
      case (code)
         3'h0: dac_span = {7'h00, 7'h64};
         3'h1: dac_span = {7'h04, 7'h60};
         3'h2: dac_span = {7'h05, 7'h5F};
         3'h3: dac_span = {7'h06, 7'h60};
         3'h4: dac_span = {7'h07, 7'h5D};
         3'h5: dac_span = {7'h08, 7'h5C};
         3'h6: dac_span = {7'h0A, 7'h5A};
         default: dac_span = {7'h0F, 7'h55};
      endcase
   endfunction : dac_span

   // analog release count: 0 for code 0, else 2^(code-1)
   function automatic logic [frc_pkg::HOLD_CNT_W-1:0] ana_hold(input logic [2:0] code);
      if (code == 3'h0) begin
         ana_hold = 8'h00;
      end else begin
         ana_hold = 8'h01 << (code - 3'h1);
      end
   endfunction : ana_hold

   // digital undervoltage report count: 2^code
   function automatic logic [frc_pkg::HOLD_CNT_W-1:0] uv_hold(input logic [2:0] code);
      uv_hold = 8'h01 << code;
   endfunction : uv_hold

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edges
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic func_last;
   logic ana_last;
   logic ov_last;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {func_pulse_i, ana_entry_i, ov_above_lo_i, ov_above_hi_i, uv_below_lo_i, uv_below_hi_i};
         pin_sync <= pin_meta;
      end
   end

   logic func_s;
   logic ana_s;
   logic ov_lo_s;
   logic ov_hi_s;
   logic uv_lo_s;
   logic uv_hi_s;
   assign {func_s, ana_s, ov_lo_s, ov_hi_s, uv_lo_s, uv_hi_s} = pin_sync;

   ////////////////////////////////////////////////////////////////////////////
   // nv and shadow words
   frc_pkg::frc_phase_type phase;
   logic [frc_pkg::WORD_W-1:0] cfg_nv;
   logic [frc_pkg::WORD_W-1:0] cfg_sh;
   logic [frc_pkg::WORD_W-1:0] mask_nv;
   logic [frc_pkg::WORD_W-1:0] mask_sh;
   logic wr_cfg_nv;
   logic wr_cfg_sh;
   logic wr_mask_nv;
   logic wr_mask_sh;

   // shadow copies take the nv words once after reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase <= frc_pkg::FRC_LOAD;
      end else begin
         case (phase)
            frc_pkg::FRC_LOAD: phase <= frc_pkg::FRC_RUN;
            default: phase <= frc_pkg::FRC_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_nv <= CFG_NV_INIT;
         mask_nv <= MASK_NV_INIT;
      end else begin
         if (wr_cfg_nv) begin
            cfg_nv <= prog_wdata_i;
         end
         if (wr_mask_nv) begin
            mask_nv <= prog_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_sh <= '0;
         mask_sh <= '0;
      end else if (phase == frc_pkg::FRC_LOAD) begin
         cfg_sh <= cfg_nv;
         mask_sh <= mask_nv;
      end else begin
         if (wr_cfg_sh) begin
            cfg_sh <= prog_wdata_i;
         end
         if (wr_mask_sh) begin
            mask_sh <= prog_wdata_i;
         end
      end
   end

   logic [1:0] entry_sel;
   logic [2:0] hold_code;
   logic [1:0] ana_resp;
   assign entry_sel = cfg_sh[frc_pkg::ENTRY_HI:frc_pkg::ENTRY_LO];
   assign hold_code = cfg_sh[frc_pkg::HOLD_HI:frc_pkg::HOLD_LO];
   assign ana_resp = cfg_sh[frc_pkg::ANA_RESP_HI:frc_pkg::ANA_RESP_LO];

   ////////////////////////////////////////////////////////////////////////////
   // supply detection and flag masking
   logic ov_detect;
   logic uv_detect;
   assign ov_detect = cfg_sh[frc_pkg::BIT_OV_SEL] ? ov_hi_s : ov_lo_s;
   assign uv_detect = cfg_sh[frc_pkg::BIT_UV_SEL] ? uv_hi_s : uv_lo_s;

   logic [frc_pkg::FLAG_W-1:0] raw_flags;
   assign raw_flags = {ov_detect, uv_detect, flags_i};

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reported_flags_o <= '0;
         error_active_o <= 1'b0;
         pos_data_o <= '0;
      end else if (phase == frc_pkg::FRC_RUN) begin
         reported_flags_o <= raw_flags & ~mask_sh[frc_pkg::FLAG_W-1:0];
         error_active_o <= |(raw_flags & ~mask_sh[frc_pkg::FLAG_W-1:0]);
         pos_data_o <= pos_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hold-off counters
   frc_hold_if ana_hold_bus ();
   frc_hold_if uv_hold_bus ();

   assign ana_hold_bus.cond = error_active_o;
   assign ana_hold_bus.update = angle_update_i;
   assign ana_hold_bus.target = ana_hold(hold_code);
   assign uv_hold_bus.cond = reported_flags_o[frc_pkg::MASK_UV];
   assign uv_hold_bus.update = angle_update_i;
   assign uv_hold_bus.target = uv_hold(hold_code);

   frc_hold_counter u_ana_hold (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .hold(ana_hold_bus.counter)
   );

   frc_hold_counter u_uv_hold (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .hold(uv_hold_bus.counter)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output responses
   logic dig_resp;
   assign dig_resp = cfg_sh[frc_pkg::BIT_DIG_RESP];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_half_freq_o <= 1'b0;
         sent_diag_error_o <= 1'b0;
         dig_out_hiz_o <= 1'b0;
         ana_hiz_o <= 1'b0;
         ana_force_high_o <= 1'b0;
         ana_force_low_o <= 1'b0;
         uv_report_o <= 1'b0;
      end else begin
         pwm_half_freq_o <= error_active_o & ~dig_resp & ~sent_mode_i;
         sent_diag_error_o <= error_active_o & ~dig_resp & sent_mode_i;
         dig_out_hiz_o <= error_active_o & dig_resp;
         ana_hiz_o <= ana_hold_bus.active & (ana_resp == frc_pkg::ANA_RESP_HIZ_A
                      || ana_resp == frc_pkg::ANA_RESP_HIZ_B);
         ana_force_high_o <= ana_hold_bus.active & (ana_resp == frc_pkg::ANA_RESP_HIGH);
         ana_force_low_o <= ana_hold_bus.active & (ana_resp == frc_pkg::ANA_RESP_LOW);
         uv_report_o <= uv_hold_bus.active;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dac_span_low_pct_o <= '0;
         dac_span_high_pct_o <= '0;
         analog_filter_corner_select_o <= 1'b0;
         prog_rx_rise_level_select_o <= 1'b0;
         prog_rx_fall_level_select_o <= 1'b0;
         margin_test_en_o <= 1'b0;
      end else begin
         {dac_span_low_pct_o, dac_span_high_pct_o} <= dac_span(cfg_sh[frc_pkg::DAC_HI:frc_pkg::DAC_LO]);
         analog_filter_corner_select_o <= cfg_sh[frc_pkg::BIT_FILT];
         prog_rx_rise_level_select_o <= cfg_sh[frc_pkg::BIT_RX_RISE];
         prog_rx_fall_level_select_o <= cfg_sh[frc_pkg::BIT_RX_FALL];
         margin_test_en_o <= margin_test_req_i & ~cfg_sh[frc_pkg::BIT_TEST_DIS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // programming entry and access gating
   logic entry_seen;
   logic ana_event_seen;
   logic unlocked;
   logic trig_ov;
   logic trig_func;
   logic trig_ok;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         func_last <= 1'b0;
         ana_last <= 1'b0;
         ov_last <= 1'b0;
      end else begin
         func_last <= func_s;
         ana_last <= ana_s;
         ov_last <= ov_detect;
      end
   end

   assign trig_ov = ov_detect & ~ov_last;
   assign trig_func = func_s & ~func_last;
   always_comb begin
      case (entry_sel)
         frc_pkg::ENTRY_OV_OR_FUNC: trig_ok = trig_ov | trig_func;
         frc_pkg::ENTRY_OV_ONLY: trig_ok = trig_ov;
         frc_pkg::ENTRY_FUNC_ONLY: trig_ok = trig_func;
         default: trig_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         entry_seen <= 1'b0;
         ana_event_seen <= 1'b0;
      end else if (phase == frc_pkg::FRC_RUN) begin
         if (trig_ok) begin
            entry_seen <= 1'b1;
         end
         if (ana_s && !ana_last) begin
            ana_event_seen <= 1'b1;
         end
      end
   end

   logic unlock_ok;
   assign unlock_ok = ~(cfg_sh[frc_pkg::BIT_ANA_CODE_REQ] & analog_mode_i) | unlocked;
   assign prog_enabled_o = (phase == frc_pkg::FRC_RUN)
                           && (entry_sel != frc_pkg::ENTRY_NONE)
                           && (analog_mode_i || entry_seen)
                           && (!cfg_sh[frc_pkg::BIT_ANALOG_EVENT_ENTRY_LOCK] || !analog_mode_i || ana_event_seen);

   logic addr_known;
   logic is_nv;
   logic refuse;
   assign addr_known = prog_addr_i inside {frc_pkg::OFS_CFG_NV, frc_pkg::OFS_CFG_SHADOW, frc_pkg::OFS_MASK_NV,
                                           frc_pkg::OFS_MASK_SHADOW, frc_pkg::OFS_UNLOCK, frc_pkg::OFS_STATUS};
   assign is_nv = (prog_addr_i == frc_pkg::OFS_CFG_NV) || (prog_addr_i == frc_pkg::OFS_MASK_NV);
   assign refuse = !prog_enabled_o || !addr_known
                   || (prog_we_i && is_nv && cfg_sh[frc_pkg::MEMLOCK_HI:frc_pkg::MEMLOCK_LO] != 4'h0)
                   || (prog_we_i && prog_addr_i == frc_pkg::OFS_STATUS)
                   || (!prog_we_i && prog_addr_i == frc_pkg::OFS_UNLOCK)
                   || (!unlock_ok && prog_addr_i != frc_pkg::OFS_UNLOCK);

   logic do_wr;
   assign do_wr = prog_req_i & prog_we_i & ~refuse;
   assign wr_cfg_nv = do_wr && prog_addr_i == frc_pkg::OFS_CFG_NV;
   assign wr_cfg_sh = do_wr && prog_addr_i == frc_pkg::OFS_CFG_SHADOW;
   assign wr_mask_nv = do_wr && prog_addr_i == frc_pkg::OFS_MASK_NV;
   assign wr_mask_sh = do_wr && prog_addr_i == frc_pkg::OFS_MASK_SHADOW;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         unlocked <= 1'b0;
      end else if (do_wr && prog_addr_i == frc_pkg::OFS_UNLOCK && prog_wdata_i == UNLOCK_CODE) begin
         unlocked <= 1'b1;
      end
   end

   logic [frc_pkg::WORD_W-1:0] next_rdata;
   always_comb begin
      case (prog_addr_i)
         frc_pkg::OFS_CFG_NV: next_rdata = cfg_nv;
         frc_pkg::OFS_CFG_SHADOW: next_rdata = cfg_sh;
         frc_pkg::OFS_MASK_NV: next_rdata = {14'h0000, mask_nv[frc_pkg::FLAG_W-1:0]};
         frc_pkg::OFS_MASK_SHADOW: next_rdata = {14'h0000, mask_sh[frc_pkg::FLAG_W-1:0]};
         frc_pkg::OFS_STATUS: next_rdata = {8'h00, unlocked, ana_event_seen, entry_seen, uv_report_o,
                                            ana_hold_bus.active, error_active_o, reported_flags_o};
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prog_ack_o <= 1'b0;
         prog_refused_o <= 1'b0;
         prog_rdata_o <= '0;
      end else begin
         prog_ack_o <= prog_req_i & ~refuse;
         prog_refused_o <= prog_req_i & refuse;
         if (prog_req_i && !prog_we_i && !refuse) begin
            prog_rdata_o <= next_rdata;
         end
      end
   end
endmodule : frc_config_top
`default_nettype wire

// >>> tb/frc_config_asserts.sv
// port-level checks on the fault response configuration block
`timescale 1ns/10ps
`default_nettype none
module frc_config_asserts (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic prog_req_i,
   input wire logic prog_ack_o,
   input wire logic prog_refused_o,
   input wire logic prog_enabled_o,
   input wire logic [15:0] pos_data_i,
   input wire logic [15:0] pos_data_o,
   input wire logic [frc_pkg::FLAG_W-1:0] reported_flags_o,
   input wire logic error_active_o,
   input wire logic pwm_half_freq_o,
   input wire logic sent_diag_error_o,
   input wire logic dig_out_hiz_o,
   input wire logic ana_hiz_o,
   input wire logic ana_force_high_o,
   input wire logic ana_force_low_o,
   input wire logic [frc_pkg::PCT_W-1:0] dac_span_low_pct_o,
   input wire logic [frc_pkg::PCT_W-1:0] dac_span_high_pct_o,
   input wire logic margin_test_req_i,
   input wire logic margin_test_en_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_req_answer: assert property (prog_req_i |=> prog_ack_o != prog_refused_o)
      else $error("bad answer");
   a_closed_refuse: assert property (prog_req_i && !prog_enabled_o |=> prog_refused_o)
      else $error("taken while closed");
   a_pos_pass: assert property ($past(reset_n_i, 2) |-> pos_data_o == $past(pos_data_i))
      else $error("position altered");
   a_err_any: assert property (error_active_o == (|reported_flags_o))
      else $error("error state mismatch");
   a_dig_hiz: assert property (dig_out_hiz_o |-> $past(error_active_o) && !pwm_half_freq_o && !sent_diag_error_o)
      else $error("stray high-z");
   a_dig_half: assert property ((pwm_half_freq_o || sent_diag_error_o) |-> $past(error_active_o)
      && !(pwm_half_freq_o && sent_diag_error_o))
      else $error("stray digital response");
   a_margin_gate: assert property (margin_test_en_o |-> $past(margin_test_req_i))
      else $error("stray margin test");
   a_ana_onehot: assert property ($onehot0({ana_hiz_o, ana_force_high_o, ana_force_low_o}))
      else $error("analog responses overlap");
   a_dac_span: assert property (dac_span_high_pct_o != 7'h00 |->
      (8'(dac_span_low_pct_o) + 8'(dac_span_high_pct_o)) inside {8'h64, 8'h66})
      else $error("bad dac span");
endmodule : frc_config_asserts

bind frc_config_top frc_config_asserts i_asserts (.*);
`default_nettype wire

// >>> tb/frc_prog_model.sv
// programmer model on the far side of the request port
`timescale 1ns/10ps
`default_nettype none
module frc_prog_model (
   input wire logic clk_i,
   output logic req_o,
   output logic we_o,
   output logic [6:0] addr_o,
   output logic [25:0] wdata_o,
   input wire logic ack_i,
   input wire logic refused_i,
   input wire logic [25:0] rdata_i
);
   initial {req_o, we_o, addr_o, wdata_o} = '0;
   // one pulse per word, released lines show the inverse
   task automatic access(input logic w, input logic [6:0] a, input logic [25:0] d,
         output logic [1:0] r, output logic [25:0] q);
      @(posedge clk_i);
      {req_o, we_o, addr_o, wdata_o} <= {1'b1, w, a, d};
      @(posedge clk_i);
      {req_o, we_o, addr_o, wdata_o} <= {1'b0, ~w, ~a, ~d};
      #1;
      r = {ack_i, refused_i};
      q = rdata_i;
   endtask : access
endmodule : frc_prog_model
`default_nettype wire

// >>> tb/fault_response_config_tb_top.sv
// self-checking bench for the fault response configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module fault_response_config_tb_top;
   localparam logic [25:0] CFG_INIT = 26'h0001C00;
   localparam logic [6:0] SH = frc_pkg::OFS_CFG_SHADOW;
   localparam logic [6:0] NV = frc_pkg::OFS_CFG_NV;
   localparam logic [13:0] SPAN [8] = '{14'h0064, 14'h0260, 14'h02DF, 14'h0360, 14'h03DD, 14'h045C,
      14'h055A, 14'h07D5};
   logic clk_i, reset_n_i, prog_req_i, prog_we_i, prog_ack_o, prog_refused_o, prog_enabled_o;
   logic [6:0] prog_addr_i, dac_span_low_pct_o, dac_span_high_pct_o;
   logic [25:0] prog_wdata_i, prog_rdata_o;
   logic analog_mode_i, sent_mode_i, func_pulse_i, ana_entry_i, angle_update_i, margin_test_req_i;
   logic ov_above_lo_i, ov_above_hi_i, uv_below_lo_i, uv_below_hi_i, margin_test_en_o, uv_report_o;
   logic [9:0] flags_i;
   logic [15:0] pos_data_i, pos_data_o;
   logic [11:0] reported_flags_o;
   logic error_active_o, pwm_half_freq_o, sent_diag_error_o, dig_out_hiz_o;
   logic ana_hiz_o, ana_force_high_o, ana_force_low_o, analog_filter_corner_select_o;
   logic prog_rx_rise_level_select_o, prog_rx_fall_level_select_o;
   int n_errors = 0;
   int n_tests = 0;

   frc_config_top #(.CFG_NV_INIT(CFG_INIT)) i_dut (.*);
   frc_prog_model i_prog (.clk_i, .req_o(prog_req_i), .we_o(prog_we_i), .addr_o(prog_addr_i),
      .wdata_o(prog_wdata_i), .ack_i(prog_ack_o), .refused_i(prog_refused_o), .rdata_i(prog_rdata_o));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] ana_exp(input logic [1:0] c);
      ana_exp = (c == 2'h1) ? 3'h2 : (c == 2'h2) ? 3'h1 : 3'h4;
   endfunction : ana_exp

   function automatic int hold_n(input int c);
      hold_n = (c == 0) ? 0 : (1 << (c - 1));
   endfunction : hold_n

   task automatic close_out();
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic acc(input logic w, input logic [6:0] a, input logic [25:0] d, input logic [1:0] e,
         output logic [25:0] q);
      logic [1:0] r;
      i_prog.access(w, a, d, r, q);
      `CHK(r, e)
   endtask : acc

   task automatic upd();
      @(posedge clk_i) angle_update_i <= 1'b1;
      @(posedge clk_i) angle_update_i <= 1'b0;
   endtask : upd

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      close_out();
   end

   initial begin : main
      logic [25:0] q, w, m;
      logic [11:0] f;
      {reset_n_i, analog_mode_i, sent_mode_i, func_pulse_i, ana_entry_i} = 5'h08;
      {angle_update_i, margin_test_req_i, flags_i, pos_data_i} = '0;
      {ov_above_lo_i, ov_above_hi_i, uv_below_lo_i, uv_below_hi_i} = 4'h0;
      void'($urandom(80693));
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK({dac_span_low_pct_o, dac_span_high_pct_o}, SPAN[7])
      acc(1'b0, NV, 26'h0, 2'h2, q);
      `CHK(q, CFG_INIT)
      for (int i = 0; i < 12; i++) begin
         w = 26'($urandom()) & 26'h003FFFB;
         acc(1'b1, SH, w, 2'h2, q);
         acc(1'b0, SH, 26'h0, 2'h2, q);
         `CHK(q, w)
         `CHK({dac_span_low_pct_o, dac_span_high_pct_o}, SPAN[w[12:10]])
         `CHK(analog_filter_corner_select_o, w[9])
         `CHK({prog_rx_rise_level_select_o, prog_rx_fall_level_select_o}, w[1:0])
      end
      for (int i = 0; i < 24; i++) begin
         m = 26'($urandom()) & 26'h0000FFF;
         w = 26'($urandom()) & 26'h00701FB;
         acc(1'b1, frc_pkg::OFS_MASK_SHADOW, m, 2'h2, q);
         acc(1'b1, SH, w, 2'h2, q);
         @(posedge clk_i);
         {ov_above_lo_i, ov_above_hi_i, uv_below_lo_i, uv_below_hi_i} <= 4'($urandom());
         flags_i <= 10'($urandom()) & 10'($urandom()) & 10'($urandom());
         {pos_data_i, sent_mode_i, margin_test_req_i} <= 18'($urandom());
         repeat (6) @(posedge clk_i);
         #1;
         f = {w[17] ? ov_above_hi_i : ov_above_lo_i, w[16] ? uv_below_hi_i : uv_below_lo_i, flags_i} & ~m[11:0];
         `CHK(reported_flags_o, f)
         `CHK(error_active_o, |f)
         `CHK(pos_data_o, pos_data_i)
         `CHK(dig_out_hiz_o, w[8] & (|f))
         `CHK({pwm_half_freq_o, sent_diag_error_o}, {2{!w[8] && |f}} & {!sent_mode_i, sent_mode_i})
         `CHK(margin_test_en_o, margin_test_req_i & !w[18])
         if (|f) `CHK({ana_hiz_o, ana_force_high_o, ana_force_low_o}, ana_exp(w[7:6]))
      end
      {ov_above_lo_i, ov_above_hi_i, uv_below_lo_i, uv_below_hi_i} <= 4'h0;
      acc(1'b1, frc_pkg::OFS_MASK_SHADOW, 26'h0, 2'h2, q);
      for (int c = 1; c < 5; c++) begin
         acc(1'b1, SH, {18'h0, 2'h1, 3'(c), 3'h0}, 2'h2, q);
         @(posedge clk_i) {uv_below_lo_i, flags_i} <= 11'h401;
         repeat (4) @(posedge clk_i);
         {uv_below_lo_i, flags_i} <= 11'h000;
         repeat (4) @(posedge clk_i);
         repeat (hold_n(c) - 1) upd();
         #1;
         `CHK(ana_force_high_o, 1'b1)
         upd();
         repeat (3) @(posedge clk_i);
         #1;
         `CHK(ana_force_high_o, 1'b0)
         `CHK(uv_report_o, 1'b1)
         repeat (hold_n(c)) upd();
         repeat (3) @(posedge clk_i);
         #1;
         `CHK(uv_report_o, 1'b0)
      end
      acc(1'b1, SH, 26'h0000004, 2'h2, q);
      `CHK(prog_enabled_o, 1'b0)
      acc(1'b0, SH, 26'h0, 2'h1, q);
      @(posedge clk_i) ana_entry_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK(prog_enabled_o, 1'b1)
      acc(1'b1, SH, 26'h2000000, 2'h2, q);
      acc(1'b0, SH, 26'h0, 2'h1, q);
      acc(1'b1, frc_pkg::OFS_UNLOCK, frc_pkg::UNLOCK_CODE_DEFAULT, 2'h2, q);
      acc(1'b0, SH, 26'h0, 2'h2, q);
      `CHK(q, 26'h2000000)
      acc(1'b0, 7'h00, 26'h0, 2'h1, q);
      acc(1'b1, NV, 26'h0001234, 2'h2, q);
      acc(1'b1, SH, 26'h0200000, 2'h2, q);
      acc(1'b1, NV, 26'h0, 2'h1, q);
      acc(1'b0, NV, 26'h0, 2'h2, q);
      `CHK(q, 26'h0001234)
      acc(1'b1, SH, 26'h0180000, 2'h2, q);
      acc(1'b1, SH, 26'h0, 2'h1, q);
      `CHK(prog_enabled_o, 1'b0)
      @(posedge clk_i) reset_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK(prog_enabled_o, 1'b1)
      @(posedge clk_i) analog_mode_i <= 1'b0;
      #1;
      `CHK(prog_enabled_o, 1'b0)
      @(posedge clk_i) func_pulse_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK(prog_enabled_o, 1'b1)
      close_out();
   end
endmodule : fault_response_config_tb_top
`default_nettype wire
